// [logic/cfg_ctrl_defines.svh]
// Constants for the configuration control register bank.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef CFG_CTRL_DEFINES_SVH
`define CFG_CTRL_DEFINES_SVH
// ==========================================================
// Register offsets
`define CFG_OFF_CONTROL 8'h00
`define CFG_OFF_UNLOCK_STATUS 8'h04
`define CFG_OFF_PIN_SELECT 8'h10
`define CFG_OFF_MODULE_DISABLE 8'h20
// ==========================================================
// Field positions
`define CFG_BIT_PIN_SELECT_LOCK 13
`define CFG_BIT_MODULE_DISABLE_LOCK 12
`define CFG_BIT_DEBUG_PORT_ENABLE 3
`define CFG_BIT_TWO_WIRE_DATA_OUT_ENABLE 0
`define CFG_BIT_UNLOCK_ARMED 0
// ==========================================================
// Reset values
`define CFG_RST_CONTROL 32'h0000_0001
`define CFG_RST_BANK 32'h0000_0000
`endif

// [logic/cfg_ctrl_pkg.sv]
// Types shared by the configuration control bank.
// Assumes cfg_ctrl_defines.svh supplies the numeric constants.
package cfg_ctrl_pkg;
    typedef enum logic [2:0] {
        SEL_CONTROL,
        SEL_UNLOCK,
        SEL_PIN_SELECT,
        SEL_MODULE_DISABLE,
        SEL_NONE
    } reg_sel_t;
endpackage : cfg_ctrl_pkg

// [logic/cfg_word_store.sv]
// Small store of lockable configuration words with registered read data.
// Assumes the caller decides when a write is allowed.
`include "cfg_ctrl_defines.svh"
module cfg_word_store #(
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `CFG_RST_BANK;
            end
        end else if (we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    mem_q[waddr_i][8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `CFG_RST_BANK;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule : cfg_word_store

// [logic/config_lock_debug_control.sv]
// Configuration control register with lock bits guarding pin-select and
// module-disable banks, plus debug port enables.
// Assumes a classic Wishbone master on clk_i and a one-cycle unlock grant.
`include "cfg_ctrl_defines.svh"

// Overview of operation
// - While the pin-select lock is 1, writes to the pin-select words are dropped.
// - While the module-disable lock is 1, writes to the module-disable words are dropped.
// - Bit 3 turns the debug test port on when 1 and resets to 0.
// - Bit 0 makes the two-wire debug protocol use data out when 1 and resets to 1.
// - The lock bits change only on a write that follows an unlock grant.
// - Bits 31-14, 11-4 and 2-1 read as zero and ignore writes.
module config_lock_debug_control
    import cfg_ctrl_pkg::*;
#(
    parameter int BANK_DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic unlock_grant_i,
    output logic pin_select_lock_o,
    output logic module_disable_lock_o,
    output logic debug_port_enable_o,
    output logic two_wire_data_out_enable_o
);
    localparam int AW = $clog2(BANK_DEPTH);

    // ==========================================================
    // Address decode
    function automatic reg_sel_t decode(input logic [7:0] a);
        if (a == `CFG_OFF_CONTROL) return SEL_CONTROL;
        if (a == `CFG_OFF_UNLOCK_STATUS) return SEL_UNLOCK;
        if (a[7:4] == 4'(`CFG_OFF_PIN_SELECT >> 4) && a[1:0] == 2'h0 && a[3:2] < BANK_DEPTH)
            return SEL_PIN_SELECT;
        if (a[7:4] == 4'(`CFG_OFF_MODULE_DISABLE >> 4) && a[1:0] == 2'h0 && a[3:2] < BANK_DEPTH)
            return SEL_MODULE_DISABLE;
        return SEL_NONE;
    endfunction : decode

    reg_sel_t sel_now;
    logic req;
    logic wr;
    logic ack_q;
    logic err_q;
    logic rd_pend_q;
    reg_sel_t rsel_q;
    logic pin_lock_q;
    logic mod_lock_q;
    logic dbg_en_q;
    logic tdo_en_q;
    logic armed_q;
    logic lock_wr;
    logic ps_we;
    logic md_we;
    logic [31:0] ps_rdata;
    logic [31:0] md_rdata;

    assign sel_now = decode(adr_i);
    // Request taken once; a second cycle waits for ack to drop
    assign req = cyc_i && stb_i && !ack_q && !err_q && !rd_pend_q;
    assign wr = req && we_i;

    // ==========================================================
    // Bus handshake: writes answer next cycle, all mapped reads one later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rsel_q <= SEL_NONE;
        end else begin
            // Reads wait one more cycle for the registered bank word
            ack_q <= (wr && sel_now != SEL_NONE) || rd_pend_q;
            err_q <= req && sel_now == SEL_NONE;
            rd_pend_q <= req && !we_i && sel_now != SEL_NONE;
            if (req) rsel_q <= sel_now;
        end
    end
    assign ack_o = ack_q;
    assign err_o = err_q;

    // ==========================================================
    // Unlock arming
    assign lock_wr = wr && sel_now == SEL_CONTROL && sel_i[1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (unlock_grant_i) begin
            armed_q <= 1'b1;
        end else if (lock_wr) begin
            armed_q <= 1'b0;
        end
    end

    // ==========================================================
    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_lock_q <= 1'(`CFG_RST_CONTROL >> `CFG_BIT_PIN_SELECT_LOCK);
            mod_lock_q <= 1'(`CFG_RST_CONTROL >> `CFG_BIT_MODULE_DISABLE_LOCK);
        end else if (lock_wr && armed_q) begin
            pin_lock_q <= dat_i[`CFG_BIT_PIN_SELECT_LOCK];
            mod_lock_q <= dat_i[`CFG_BIT_MODULE_DISABLE_LOCK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_en_q <= 1'(`CFG_RST_CONTROL >> `CFG_BIT_DEBUG_PORT_ENABLE);
            tdo_en_q <= 1'(`CFG_RST_CONTROL >> `CFG_BIT_TWO_WIRE_DATA_OUT_ENABLE);
        end else if (wr && sel_now == SEL_CONTROL && sel_i[0]) begin
            dbg_en_q <= dat_i[`CFG_BIT_DEBUG_PORT_ENABLE];
            tdo_en_q <= dat_i[`CFG_BIT_TWO_WIRE_DATA_OUT_ENABLE];
        end
    end

    assign pin_select_lock_o = pin_lock_q;
    assign module_disable_lock_o = mod_lock_q;
    assign debug_port_enable_o = dbg_en_q;
    assign two_wire_data_out_enable_o = tdo_en_q;

    // ==========================================================
    // Guarded banks
    assign ps_we = wr && sel_now == SEL_PIN_SELECT && !pin_lock_q;
    assign md_we = wr && sel_now == SEL_MODULE_DISABLE && !mod_lock_q;

    cfg_word_store #(.DEPTH(BANK_DEPTH), .AW(AW)) u_pin_select (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(ps_we),
        .waddr_i(adr_i[2 +: AW]),
        .sel_i(sel_i),
        .wdata_i(dat_i),
        .raddr_i(adr_i[2 +: AW]),
        .rdata_o(ps_rdata)
    );

    cfg_word_store #(.DEPTH(BANK_DEPTH), .AW(AW)) u_module_disable (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(md_we),
        .waddr_i(adr_i[2 +: AW]),
        .sel_i(sel_i),
        .wdata_i(dat_i),
        .raddr_i(adr_i[2 +: AW]),
        .rdata_o(md_rdata)
    );

    // ==========================================================
    // Read data, registered at the acking edge
    logic [31:0] ctrl_word;
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CFG_BIT_PIN_SELECT_LOCK] = pin_lock_q;
        ctrl_word[`CFG_BIT_MODULE_DISABLE_LOCK] = mod_lock_q;
        ctrl_word[`CFG_BIT_DEBUG_PORT_ENABLE] = dbg_en_q;
        ctrl_word[`CFG_BIT_TWO_WIRE_DATA_OUT_ENABLE] = tdo_en_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            unique case (rsel_q)
                SEL_CONTROL: dat_o <= ctrl_word;
                SEL_UNLOCK: dat_o <= {31'h0000_0000, armed_q};
                SEL_PIN_SELECT: dat_o <= ps_rdata;
                SEL_MODULE_DISABLE: dat_o <= md_rdata;
                SEL_NONE: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Checks
    // The addressed word is watched; the master holds the address through the ack edge
    property p_ps_blocked;
        @(posedge clk_i) disable iff (rst_i)
        (wr && sel_now == SEL_PIN_SELECT && pin_lock_q)
            |=> $stable(u_pin_select.mem_q[adr_i[2 +: AW]]);
    endproperty
    a_ps_blocked: assert property (p_ps_blocked)
        else $error("pin-select word changed while locked");
    property p_md_blocked;
        @(posedge clk_i) disable iff (rst_i)
        (wr && sel_now == SEL_MODULE_DISABLE && mod_lock_q)
            |=> $stable(u_module_disable.mem_q[adr_i[2 +: AW]]);
    endproperty
    a_md_blocked: assert property (p_md_blocked)
        else $error("module-disable word changed while locked");
    property p_lock_needs_unlock;
        @(posedge clk_i) disable iff (rst_i)
        ($changed(pin_lock_q) || $changed(mod_lock_q)) |-> $past(armed_q) && $past(lock_wr);
    endproperty
    a_lock_needs_unlock: assert property (p_lock_needs_unlock)
        else $error("lock bit changed without unlock");
    property p_arm_once;
        @(posedge clk_i) disable iff (rst_i)
        (lock_wr && !unlock_grant_i) |=> !armed_q;
    endproperty
    a_arm_once: assert property (p_arm_once)
        else $error("unlock grant not consumed by lock write");
    property p_arm_set;
        @(posedge clk_i) disable iff (rst_i) unlock_grant_i |=> armed_q;
    endproperty
    a_arm_set: assert property (p_arm_set)
        else $error("unlock grant did not arm");
    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        (ack_q && rsel_q == SEL_CONTROL && !$past(we_i)) |-> (dat_o & 32'hFFFF_CFF6) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");
    property p_reset_vals;
        @(posedge clk_i) rst_i |=> tdo_en_q && !dbg_en_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("debug enables have wrong reset value");
    property p_dbg_follows;
        @(posedge clk_i) disable iff (rst_i)
        (wr && sel_now == SEL_CONTROL && sel_i[0])
            |=> dbg_en_q == $past(dat_i[`CFG_BIT_DEBUG_PORT_ENABLE]);
    endproperty
    a_dbg_follows: assert property (p_dbg_follows)
        else $error("debug enable did not take written value");
    property p_tdo_follows;
        @(posedge clk_i) disable iff (rst_i)
        (wr && sel_now == SEL_CONTROL && sel_i[0])
            |=> tdo_en_q == $past(dat_i[`CFG_BIT_TWO_WIRE_DATA_OUT_ENABLE]);
    endproperty
    a_tdo_follows: assert property (p_tdo_follows)
        else $error("data-out enable did not take written value");
    property p_read_ack_late;
        @(posedge clk_i) disable iff (rst_i)
        (req && !we_i && sel_now != SEL_NONE) |=> !ack_q ##1 ack_q;
    endproperty
    a_read_ack_late: assert property (p_read_ack_late)
        else $error("read not acknowledged two cycles after request");
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_q |=> !ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    c_lock_write: cover property (@(posedge clk_i) disable iff (rst_i) lock_wr && armed_q);
    c_ps_blocked: cover property (@(posedge clk_i) disable iff (rst_i)
        wr && sel_now == SEL_PIN_SELECT && pin_lock_q);
    c_err: cover property (@(posedge clk_i) disable iff (rst_i) err_q);
endmodule : config_lock_debug_control

// [test/config_lock_debug_control_tb_top.sv]
// Self-checking bench for the configuration control register bank.
// Assumes the bank answers classic Wishbone cycles on clk_i and takes a one-cycle grant.
module config_lock_debug_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic unlock_grant_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, err_o;
    logic pin_select_lock_o, module_disable_lock_o;
    logic debug_port_enable_o, two_wire_data_out_enable_o;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int comparisons = 0;

    config_lock_debug_control #(.BANK_DEPTH(4)) u_config_lock_debug_control (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .unlock_grant_i(unlock_grant_i),
        .pin_select_lock_o(pin_select_lock_o), .module_disable_lock_o(module_disable_lock_o),
        .debug_port_enable_o(debug_port_enable_o),
        .two_wire_data_out_enable_o(two_wire_data_out_enable_o)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // ==========================================================
    // Bus and compare tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Waits for a rising edge, then holds the request until ack or err is seen at a rising edge and drops it
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'h0, 32'h0000_0000);
        check(name, rd, exp);
    endtask : rd_chk

    task automatic grant();
        @(posedge clk_i);
        unlock_grant_i <= 1'b1;
        @(posedge clk_i);
        unlock_grant_i <= 1'b0;
    endtask : grant

    task automatic outs(input logic [3:0] exp);
        check("outputs", {28'h0, pin_select_lock_o, module_disable_lock_o,
                          debug_port_enable_o, two_wire_data_out_enable_o}, {28'h0, exp});
    endtask : outs

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Watchdog, far beyond the roughly one hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        tally_and_finish();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        outs(4'b0001);
        rd_chk("control reset", 8'h00, 32'h0000_0001);
        // Without a grant only bits 3 and 0 may take the all-ones write
        wb(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        rd_chk("control ones", 8'h00, 32'h0000_0009);
        outs(4'b0011);
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0000);
        outs(4'b0000);
        wb(1'b1, 8'h10, 4'hF, 32'hA5A5_5A5A);
        wb(1'b1, 8'h20, 4'hF, 32'h1234_5678);
        rd_chk("pin select open", 8'h10, 32'hA5A5_5A5A);
        rd_chk("module disable open", 8'h20, 32'h1234_5678);
        grant();
        wb(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("armed", {31'h0, rd[0]}, 32'h0000_0001);
        wb(1'b1, 8'h00, 4'h2, 32'h0000_3000);
        outs(4'b1100);
        wb(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("disarmed", {31'h0, rd[0]}, 32'h0000_0000);
        // Locked banks acknowledge but keep their contents
        wb(1'b1, 8'h10, 4'hF, 32'h0F0F_0F0F);
        wb(1'b1, 8'h2C, 4'hF, 32'hFFFF_FFFF);
        rd_chk("pin select locked", 8'h10, 32'hA5A5_5A5A);
        rd_chk("module disable locked", 8'h2C, 32'h0000_0000);
        // One grant allows one lock write only
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0008);
        rd_chk("locks kept", 8'h00, 32'h0000_3008);
        // A write without lane 1 leaves the grant armed for the next one
        grant();
        wb(1'b1, 8'h00, 4'h1, 32'h0000_0001);
        wb(1'b1, 8'h00, 4'h2, 32'h0000_0000);
        outs(4'b0001);
        wb(1'b1, 8'h1C, 4'hF, 32'hC3C3_3C3C);
        rd_chk("pin select reopened", 8'h1C, 32'hC3C3_3C3C);
        wb(1'b1, 8'h2C, 4'h3, 32'hFFFF_BEEF);
        rd_chk("module disable lanes", 8'h2C, 32'h0000_BEEF);
        // A reset in mid-run must restore both debug enables
        wb(1'b1, 8'h00, 4'h1, 32'h0000_0008);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        outs(4'b0001);
        rd_chk("control after reset", 8'h00, 32'h0000_0001);
        wb(1'b0, 8'h80, 4'h0, 32'h0000_0000);
        check("unmapped err", {31'h0, er}, 32'h0000_0001);
        tally_and_finish();
    end
endmodule : config_lock_debug_control_tb_top
